// ### core/mode_ctrl_pkg.sv
// Constants, register map and types for the operating-mode release and clock switch block.
// Assumes one 50 MHz system clock that stands for fc; fs is a one-cycle enable from a divider.
package mode_ctrl_pkg;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL_2 = 8'h00;
    localparam logic [7:0] ADDR_TIME_BASE_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_FLASH_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h03;
    localparam int FAST_OSC_BIT = 7;
    localparam int SLOW_OSC_BIT = 6;
    localparam int CLOCK_SELECT_BIT = 5;
    localparam int HALT_BIT = 2;
    localparam int TB_ENABLE_BIT = 7;
    localparam int TB_SELECT_LSB = 0;
    localparam int AUTO_POWERDOWN_BIT = 1;
    localparam int STATUS_HALTED_BIT = 7;
    localparam int STATUS_WAITING_BIT = 6;
    localparam int STATUS_MAIN_SLOW_BIT = 5;
    localparam logic RESET_FAST_OSC = 1'b1;
    localparam logic RESET_SLOW_OSC = 1'b0;
    localparam logic RESET_CLOCK_SELECT = 1'b0;
    localparam logic RESET_AUTO_POWERDOWN = 1'b0;
    localparam int FC_HZ = 50000000;
    localparam int FS_HZ = 32768;
    localparam int FS_DIVIDE = FC_HZ / FS_HZ;
    localparam int IDLE_WAIT_FC = 1 << 10;
    localparam int SLEEP_WAIT_FS = 1 << 3;
    localparam logic [1:0] MODE_SINGLE_RUN = 2'h0;
    localparam logic [1:0] MODE_DUAL_RUN = 2'h1;
    localparam logic [1:0] MODE_SLOW_FAST_ON = 2'h2;
    localparam logic [1:0] MODE_SLOW_FAST_OFF = 2'h3;
    typedef enum logic [1:0] {RUN, DEEP, WAIT} state_type;
endpackage : mode_ctrl_pkg

// ### core/mode_ctrl.sv
// Deep idle/sleep release, CPU wait after release and run/slow clock switching.
// Assumes the CPU core supplies the interrupt flags and the watchdog request on sys_clk.
`timescale 1ns/100ps
module mode_ctrl import mode_ctrl_pkg::*; #(
    parameter int FS_DIV = FS_DIVIDE,
    parameter int TB_WIDTH = 22
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    // Flags from the CPU core.
    input wire logic interruptMasterFlag,
    input wire logic timeBaseIrqEnableFlag,
    input wire logic watchdogIrq,
    // Mode and clock controls.
    output logic cpuHalted,
    output logic cpuWaiting,
    output logic peripheralClockOn,
    output logic mainClockSlow,
    output logic fastOscOn,
    output logic slowOscOn,
    output logic [1:0] runMode,
    // Interrupt events.
    output logic timeBaseLatchSet,
    output logic timeBaseIrqService,
    output logic watchdogService
);
    typedef struct packed {
        state_type state;
        logic [1:0] savedMode;
        logic savedSleep;
        logic savedIrq;
        logic needWait;
        logic [10:0] waitCount;
        logic [15:0] fsCount;
        logic fsTick;
        logic [TB_WIDTH-1:0] tbCount;
        logic tapPrev;
        logic fastOsc;
        logic slowOsc;
        logic clkSelect;
        logic haltBit;
        logic tbEnable;
        logic [2:0] tbSelect;
        logic autoPowerDown;
        logic mainSlow;
        logic periphOn;
        logic halted;
        logic waiting;
        logic tbLatchSet;
        logic tbService;
        logic wdtService;
        logic [1:0] mode;
        logic [7:0] rdata;
    } core_type;

    core_type s;
    core_type next_s;

    function automatic logic [1:0] modeOf(input logic fast, input logic slow,
                                          input logic sel);
        if (!slow) begin
            return MODE_SINGLE_RUN;
        end else if (!sel) begin
            return MODE_DUAL_RUN;
        end else if (fast) begin
            return MODE_SLOW_FAST_ON;
        end
        return MODE_SLOW_FAST_OFF;
    endfunction : modeOf

    // The select field picks one divider stage as the time-base source clock.
    function automatic logic tapOf(input logic [TB_WIDTH-1:0] count, input logic [2:0] sel);
        case (sel)
            3'h0: return count[TB_WIDTH-1];
            3'h1: return count[TB_WIDTH-3];
            3'h2: return count[TB_WIDTH-6];
            3'h3: return count[TB_WIDTH-8];
            3'h4: return count[TB_WIDTH-9];
            3'h5: return count[TB_WIDTH-10];
            3'h6: return count[TB_WIDTH-11];
            default: return count[TB_WIDTH-14];
        endcase
    endfunction : tapOf

    logic tap;
    logic tbFall;
    logic haltWrite;
    logic irqRelease;
    logic waitDone;

    always_comb begin
        next_s = s;
        tap = tapOf(s.tbCount, s.tbSelect);
        tbFall = s.tapPrev && !tap;
        haltWrite = writeStrobe && address == ADDR_SYSTEM_CONTROL_2 && writeData[HALT_BIT];
        irqRelease = interruptMasterFlag && timeBaseIrqEnableFlag && s.tbEnable;
        waitDone = s.savedSleep ? (s.fsTick && s.waitCount == 11'(SLEEP_WAIT_FS - 1))
                                : (s.waitCount == 11'(IDLE_WAIT_FC - 1));
        next_s.tbLatchSet = 1'b0;
        next_s.tbService = 1'b0;
        next_s.wdtService = 1'b0;
        next_s.tapPrev = tap;
        // The fs enable keeps running in every mode so slow counts stay honest.
        next_s.fsTick = s.fsCount == 16'(FS_DIV - 1);
        next_s.fsCount = next_s.fsTick ? 16'h0000 : s.fsCount + 16'h0001;
        // The time base runs on fc in idle and on fs while the slow clock drives the core.
        if (s.mainSlow ? s.fsTick : 1'b1) begin
            next_s.tbCount = s.tbCount + TB_WIDTH'(1);
        end
        // The core switches to fast only on an fs boundary, which is its sync point.
        if (s.clkSelect) begin
            next_s.mainSlow = 1'b1;
        end else if (s.fsTick) begin
            next_s.mainSlow = 1'b0;
        end
        next_s.rdata = 8'h00;
        if (readStrobe) begin
            case (address)
                ADDR_SYSTEM_CONTROL_2: begin
                    next_s.rdata[FAST_OSC_BIT] = s.fastOsc;
                    next_s.rdata[SLOW_OSC_BIT] = s.slowOsc;
                    next_s.rdata[CLOCK_SELECT_BIT] = s.clkSelect;
                    next_s.rdata[HALT_BIT] = s.haltBit;
                end
                ADDR_TIME_BASE_CONTROL: begin
                    next_s.rdata[TB_ENABLE_BIT] = s.tbEnable;
                    next_s.rdata[TB_SELECT_LSB +: 3] = s.tbSelect;
                end
                ADDR_FLASH_CONTROL: begin
                    next_s.rdata[AUTO_POWERDOWN_BIT] = s.autoPowerDown;
                end
                ADDR_MODE_STATUS: begin
                    next_s.rdata[STATUS_HALTED_BIT] = s.halted;
                    next_s.rdata[STATUS_WAITING_BIT] = s.waiting;
                    next_s.rdata[STATUS_MAIN_SLOW_BIT] = s.mainSlow;
                    next_s.rdata[1:0] = s.mode;
                end
                default: next_s.rdata = 8'h00;
            endcase
        end
        case (s.state)
            RUN: begin
                // The CPU is stopped outside run, so writes there cannot occur and are dropped.
                if (writeStrobe) begin
                    case (address)
                        ADDR_SYSTEM_CONTROL_2: begin
                            next_s.fastOsc = writeData[FAST_OSC_BIT];
                            next_s.slowOsc = writeData[SLOW_OSC_BIT];
                            next_s.clkSelect = writeData[CLOCK_SELECT_BIT];
                        end
                        ADDR_TIME_BASE_CONTROL: begin
                            next_s.tbEnable = writeData[TB_ENABLE_BIT];
                            next_s.tbSelect = writeData[TB_SELECT_LSB +: 3];
                        end
                        ADDR_FLASH_CONTROL: begin
                            next_s.autoPowerDown = writeData[AUTO_POWERDOWN_BIT];
                        end
                        default: next_s.rdata = next_s.rdata;
                    endcase
                end
                next_s.mode = modeOf(next_s.fastOsc, next_s.slowOsc, next_s.clkSelect);
                if (haltWrite && watchdogIrq) begin
                    next_s.wdtService = 1'b1;
                end else if (haltWrite) begin
                    next_s.state = DEEP;
                    next_s.haltBit = 1'b1;
                    next_s.halted = 1'b1;
                    next_s.periphOn = 1'b0;
                    next_s.savedMode = s.mode;
                    next_s.savedSleep = s.mainSlow;
                    next_s.needWait = !s.autoPowerDown;
                    next_s.tbLatchSet = s.tbEnable;
                end
            end
            DEEP: begin
                // The edge comes from a free divider, so the first period may be short.
                if (tbFall) begin
                    next_s.haltBit = 1'b0;
                    next_s.periphOn = 1'b1;
                    next_s.savedIrq = irqRelease;
                    next_s.waitCount = 11'h000;
                    if (s.needWait) begin
                        next_s.state = WAIT;
                        next_s.waiting = 1'b1;
                    end else begin
                        next_s.state = RUN;
                        next_s.halted = 1'b0;
                        next_s.mode = s.savedMode;
                        next_s.tbService = irqRelease;
                    end
                end
            end
            WAIT: begin
                if (!s.savedSleep || s.fsTick) begin
                    next_s.waitCount = s.waitCount + 11'h001;
                end
                if (waitDone) begin
                    next_s.state = RUN;
                    next_s.halted = 1'b0;
                    next_s.waiting = 1'b0;
                    next_s.mode = s.savedMode;
                    next_s.tbService = s.savedIrq;
                end
            end
            default: next_s.state = RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.state <= RUN;
            s.fastOsc <= RESET_FAST_OSC;
            s.slowOsc <= RESET_SLOW_OSC;
            s.clkSelect <= RESET_CLOCK_SELECT;
            s.autoPowerDown <= RESET_AUTO_POWERDOWN;
            s.periphOn <= 1'b1;
            s.mode <= MODE_SINGLE_RUN;
        end else begin
            s <= next_s;
        end
    end

    assign readData = s.rdata;
    assign cpuHalted = s.halted;
    assign cpuWaiting = s.waiting;
    assign peripheralClockOn = s.periphOn;
    assign mainClockSlow = s.mainSlow;
    assign fastOscOn = s.fastOsc;
    assign slowOscOn = s.slowOsc;
    assign runMode = s.mode;
    assign timeBaseLatchSet = s.tbLatchSet;
    assign timeBaseIrqService = s.tbService;
    assign watchdogService = s.wdtService;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence deepEntry;
        s.state == RUN && haltWrite && !watchdogIrq;
    endsequence
    sequence edgeRelease;
        s.state == DEEP && tbFall;
    endsequence

    a_deep_entry: assert property (deepEntry |=> s.halted && !s.periphOn && s.haltBit)
        else $error("deep entry did not halt the core");
    a_watchdog_block: assert property (s.state == RUN && haltWrite && watchdogIrq
        |=> s.wdtService && !s.halted && s.state == RUN)
        else $error("watchdog request did not block deep entry");
    a_latch_set: assert property (deepEntry |=> s.tbLatchSet == $past(s.tbEnable))
        else $error("time-base latch mismatch on entry");
    a_edge_only: assert property (s.state == DEEP && !tbFall |=> s.state == DEEP)
        else $error("deep mode left without a time-base edge");
    a_halt_clear: assert property (edgeRelease |=> !s.haltBit
        && s.state == ($past(s.needWait) ? WAIT : RUN))
        else $error("release did not clear the halt bit");
    a_mode_restore: assert property ($fell(s.halted) |-> s.mode == s.savedMode)
        else $error("run mode not restored on release");
    a_wait_quiet: assert property (s.waiting |-> !s.tbService && s.periphOn && s.halted)
        else $error("interrupt serviced during CPU wait");
    a_wait_bound: assert property (s.state == WAIT |-> s.waitCount
        < 11'(s.savedSleep ? SLEEP_WAIT_FS : IDLE_WAIT_FC))
        else $error("CPU wait overran its length");
    a_clock_sync: assert property ($fell(s.clkSelect) |-> s.mainSlow ##1 s.mainSlow == !$past(s.fsTick))
        else $error("fast clock taken before synchronisation");

    // Release splits on whether the flash supply still needs its CPU wait.
    sequence quickRelease;
        s.state == DEEP && tbFall && !s.needWait;
    endsequence
    sequence slowRelease;
        s.state == DEEP && tbFall && s.needWait;
    endsequence
    sequence waitFinish;
        s.state == WAIT && waitDone;
    endsequence
    sequence idleStep;
        s.state == WAIT && !s.savedSleep && !waitDone;
    endsequence

    a_release_periph: assert property (edgeRelease |=> s.periphOn && !s.haltBit)
        else $error("peripheral clock not restored on release");
    a_quick_resume: assert property (quickRelease
        |=> !s.halted && !s.waiting && s.mode == $past(s.savedMode))
        else $error("release without wait did not resume the core");
    a_quick_service: assert property (quickRelease |=> s.tbService == $past(irqRelease))
        else $error("time-base service pulse wrong on release");
    a_wait_start: assert property (slowRelease
        |=> s.waiting && s.halted && s.waitCount == 11'h000)
        else $error("CPU wait did not start on release");
    a_wait_service: assert property (waitFinish
        |=> !s.halted && !s.waiting && s.tbService == $past(s.savedIrq))
        else $error("time-base service pulse wrong after CPU wait");
    a_idle_step: assert property (idleStep
        |=> s.waitCount == $past(s.waitCount) + 11'h001)
        else $error("idle CPU wait did not count fc cycles");
    a_sleep_hold: assert property (s.state == WAIT && s.savedSleep && !s.fsTick
        |=> s.waitCount == $past(s.waitCount))
        else $error("sleep CPU wait counted without an fs tick");
    a_wait_periph: assert property (s.state == WAIT
        |-> s.periphOn && s.halted && s.waiting)
        else $error("CPU wait state flags wrong");

    a_deep_dark: assert property (s.state == DEEP
        |-> !s.periphOn && s.halted && !s.waiting)
        else $error("deep mode left peripherals clocked");
    a_run_awake: assert property (s.state == RUN
        |-> !s.halted && !s.waiting && s.periphOn)
        else $error("run state with the core still halted");
    a_entry_saves: assert property (deepEntry
        |=> s.savedMode == $past(s.mode) && s.savedSleep == $past(s.mainSlow))
        else $error("mode not recorded on deep entry");
    a_entry_wait: assert property (deepEntry
        |=> s.needWait == !$past(s.autoPowerDown))
        else $error("CPU wait request wrong on deep entry");
    a_latch_origin: assert property (s.tbLatchSet
        |-> s.state == DEEP && $past(s.state) == RUN)
        else $error("time-base latch set outside deep entry");
    a_wdt_origin: assert property (s.wdtService |-> s.state == RUN && !s.halted)
        else $error("watchdog service outside run state");
    a_service_awake: assert property (s.tbService
        |-> s.state == RUN && !s.halted)
        else $error("time-base service while the core was halted");

    a_slow_select: assert property (s.clkSelect |=> s.mainSlow)
        else $error("slow clock not taken after select");
    a_fast_hold: assert property (!s.clkSelect && s.mainSlow && !s.fsTick
        |=> s.mainSlow)
        else $error("fast clock taken between fs ticks");
    a_fs_single: assert property (s.fsTick |=> !s.fsTick)
        else $error("fs enable longer than one cycle");
    a_tb_count: assert property (!s.mainSlow
        |=> s.tbCount == $past(s.tbCount) + TB_WIDTH'(1))
        else $error("time base stopped on the fast clock");
    a_halted_writes: assert property (s.state != RUN && writeStrobe
        |=> s.clkSelect == $past(s.clkSelect) && s.fastOsc == $past(s.fastOsc))
        else $error("register write taken while the core was halted");
    a_read_idle: assert property (!readStrobe |=> s.rdata == 8'h00)
        else $error("read data stood longer than one cycle");
endmodule : mode_ctrl

// ### tb/firmware_model.sv
// Firmware stand-in that drives the register port the way code on the core would.
// Assumes the block samples strobes on the rising sys_clk edge and never stalls.
`timescale 1ns/100ps
module firmware_model import mode_ctrl_pkg::*; #(
    parameter int WARM_UP = 16
) (
    // Clock.
    input wire logic sys_clk,
    // Register port.
    output logic [7:0] address,
    output logic [7:0] writeData,
    output logic writeStrobe,
    output logic readStrobe,
    input wire logic [7:0] readData
);
    initial begin
        address = 8'h00;
        writeData = 8'h00;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
    end

    // Released lines show inverted junk, so nothing can lean on stale values.
    task reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        address <= addr;
        writeData <= data;
        writeStrobe <= 1'b1;
        @(posedge sys_clk);
        writeStrobe <= 1'b0;
        address <= ~addr;
        writeData <= ~data;
    endtask : reg_write

    task reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        address <= addr;
        readStrobe <= 1'b1;
        @(posedge sys_clk);
        readStrobe <= 1'b0;
        address <= ~addr;
        #1;
        data = readData;
    endtask : reg_read

    task enter_deep(input logic [7:0] base);
        reg_write(ADDR_SYSTEM_CONTROL_2, base | (8'h01 << HALT_BIT));
    endtask : enter_deep

    task to_slow;
        reg_write(ADDR_SYSTEM_CONTROL_2, 8'hc0);
        repeat (WARM_UP) @(posedge sys_clk);
        reg_write(ADDR_SYSTEM_CONTROL_2, 8'he0);
        reg_write(ADDR_SYSTEM_CONTROL_2, 8'h60);
    endtask : to_slow

    task to_dual;
        reg_write(ADDR_SYSTEM_CONTROL_2, 8'he0);
        repeat (WARM_UP) @(posedge sys_clk);
        reg_write(ADDR_SYSTEM_CONTROL_2, 8'hc0);
    endtask : to_dual
endmodule : firmware_model

// ### tb/mode_ctrl_tb.sv
// Self-checking bench for the mode controller with a shortened divider and time base.
// Assumes firmware_model owns the register port; flags and reset are driven here.
`timescale 1ns/100ps
module mode_ctrl_tb import mode_ctrl_pkg::*;;
    localparam int FSD = 4;
    logic sys_clk, rst_n, writeStrobe, readStrobe;
    logic [7:0] address, writeData, readData, rd;
    logic interruptMasterFlag, timeBaseIrqEnableFlag, watchdogIrq;
    logic cpuHalted, cpuWaiting, peripheralClockOn, mainClockSlow, fastOscOn, slowOscOn;
    logic [1:0] runMode;
    logic timeBaseLatchSet, timeBaseIrqService, watchdogService;
    int errCount, checks, n;

    mode_ctrl #(.FS_DIV(FSD), .TB_WIDTH(14)) mode_ctrl_i (.sys_clk, .rst_n, .address,
        .writeData, .writeStrobe, .readStrobe, .readData, .interruptMasterFlag,
        .timeBaseIrqEnableFlag, .watchdogIrq, .cpuHalted, .cpuWaiting, .peripheralClockOn,
        .mainClockSlow, .fastOscOn, .slowOscOn, .runMode, .timeBaseLatchSet,
        .timeBaseIrqService, .watchdogService);
    firmware_model firmware_model_i (.sys_clk, .address, .writeData, .writeStrobe,
        .readStrobe, .readData);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic met(input int which);
        case (which)
            0: return cpuWaiting === 1'b1;
            1: return cpuHalted === 1'b0;
            default: return mainClockSlow === 1'b0;
        endcase
    endfunction : met

    // A bound that runs out ends the run at once rather than hanging.
    task wait_until(input int which, output int cnt);
        for (cnt = 1; cnt <= 3000; cnt++) begin
            @(posedge sys_clk);
            #1;
            if (met(which)) return;
        end
        errCount++;
        final_report();
    endtask : wait_until

    task set_flags(input logic master, input logic enable, input logic dog);
        @(posedge sys_clk);
        interruptMasterFlag <= master;
        timeBaseIrqEnableFlag <= enable;
        watchdogIrq <= dog;
    endtask : set_flags

    task test_reset;
        check({fastOscOn, slowOscOn, mainClockSlow, peripheralClockOn, cpuHalted}, 16'h12);
        check(runMode, 16'h0);
        firmware_model_i.reg_read(ADDR_SYSTEM_CONTROL_2, rd);
        check(rd, 16'h80);
        firmware_model_i.reg_read(8'h10, rd);
        check(rd, 16'h0);
        firmware_model_i.reg_write(ADDR_MODE_STATUS, 8'hff);
        firmware_model_i.reg_read(ADDR_MODE_STATUS, rd);
        check(rd, 16'h0);
        $display("test reset done");
    endtask : test_reset

    task test_idle_irq;
        set_flags(1'b1, 1'b1, 1'b0);
        firmware_model_i.reg_write(ADDR_TIME_BASE_CONTROL, 8'h87);
        firmware_model_i.reg_write(ADDR_FLASH_CONTROL, 8'h00);
        firmware_model_i.enter_deep(8'h80);
        #1;
        check({cpuHalted, peripheralClockOn, timeBaseLatchSet}, 16'h5);
        wait_until(0, n);
        wait_until(1, n);
        check(n, 16'd1024);
        check({timeBaseIrqService, cpuWaiting, runMode}, 16'h8);
        firmware_model_i.reg_read(ADDR_SYSTEM_CONTROL_2, rd);
        check(rd, 16'h80);
        $display("test idle interrupt release done");
    endtask : test_idle_irq

    // Master and enable flags set but time base off: release must be the plain kind.
    task test_idle_plain;
        firmware_model_i.reg_write(ADDR_TIME_BASE_CONTROL, 8'h07);
        firmware_model_i.reg_write(ADDR_FLASH_CONTROL, 8'h02);
        firmware_model_i.enter_deep(8'h80);
        #1;
        check({cpuHalted, timeBaseLatchSet}, 16'h2);
        wait_until(1, n);
        check({timeBaseIrqService, cpuWaiting, peripheralClockOn}, 16'h1);
        $display("test idle normal release done");
    endtask : test_idle_plain

    task test_watchdog;
        set_flags(1'b0, 1'b0, 1'b1);
        firmware_model_i.enter_deep(8'h80);
        #1;
        check({watchdogService, cpuHalted}, 16'h2);
        set_flags(1'b0, 1'b0, 1'b0);
        $display("test watchdog done");
    endtask : test_watchdog

    task test_slow_sleep;
        firmware_model_i.to_slow();
        #1;
        check({mainClockSlow, fastOscOn, slowOscOn, runMode}, 16'h17);
        firmware_model_i.reg_write(ADDR_FLASH_CONTROL, 8'h00);
        firmware_model_i.reg_write(ADDR_TIME_BASE_CONTROL, 8'h87);
        firmware_model_i.enter_deep(8'h60);
        wait_until(0, n);
        wait_until(1, n);
        check(n >= 7 * FSD + 1 && n <= 8 * FSD, 16'h1);
        check({mainClockSlow, runMode}, 16'h7);
        firmware_model_i.to_dual();
        #1;
        check(mainClockSlow, 16'h1);
        wait_until(2, n);
        check(n <= FSD + 1, 16'h1);
        check(runMode, 16'h1);
        $display("test slow and sleep done");
    endtask : test_slow_sleep

    task test_reset_slow;
        firmware_model_i.to_slow();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({runMode, mainClockSlow, fastOscOn, slowOscOn}, 16'h2);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        $display("test reset from slow done");
    endtask : test_reset_slow

    initial begin
        rst_n = 1'b0;
        interruptMasterFlag = 1'b0;
        timeBaseIrqEnableFlag = 1'b0;
        watchdogIrq = 1'b0;
        errCount = 0;
        checks = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_reset();
        test_idle_irq();
        test_idle_plain();
        test_watchdog();
        test_slow_sleep();
        test_reset_slow();
        final_report();
    end
endmodule : mode_ctrl_tb
